// ===== src/sld_log_decode.sv
/*
  transport-log command decoder: gates data page e1h transfers on a
  pending key-sector request and serves status page e0h reads.
  assumes task-file fields and core events come from logic on sys_clk;
  the host controller holds fields valid in the cycle cmdValid is high.
*/
`timescale 1ns/1ns
`default_nettype none
module sld_log_decode
#(
  parameter int CNT_W = 8
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // task-file command from the host controller
  input wire logic cmdValid,
  input wire logic [7:0] cmdOpcode,
  input wire logic [7:0] cmdFeature,
  input wire logic [7:0] cmdCountCur,
  input wire logic [7:0] cmdCountPrev,
  input wire logic [7:0] cmdLbaLowCur,
  input wire logic [7:0] cmdLbaMidCur,
  input wire logic [7:0] cmdLbaMidPrev,
  input wire logic [7:0] cmdLbaHighCur,
  // events from the request engine
  input wire logic keyIssued,
  input wire logic [CNT_W-1:0] keyNeedSectors,
  input wire logic bgBusy,
  input wire logic bgDone,
  input wire logic [15:0] bgStatus,
  // ata answer to the command
  output logic cmdAccept,
  output logic cmdAbort,
  output logic cmdPassOn,
  // data movement and status page requests
  output logic dataReadGo,
  output logic dataWriteGo,
  output logic statusReadGo,
  output logic [CNT_W-1:0] xferSectors,
  // status page contents
  output logic [15:0] statusCode,
  output logic requestPending
);
  import sld_pkg::*;

  // whole module state in one record
  typedef struct packed {
    logic keyPend;
    logic [CNT_W-1:0] needSect;
    logic [15:0] lastStat;
    logic accept;
    logic abort;
    logic passOn;
    logic rdGo;
    logic wrGo;
    logic statGo;
    logic [CNT_W-1:0] xfer;
    logic [15:0] statOut;
  } sld_state_t;

  sld_state_t st_ff;
  sld_state_t nxt_st;
  sld_dec_if dec ();
  logic [CNT_W-1:0] reqCount;
  logic countOver;

  // snapshot goes straight to the classifier; one driver for the record
  assign dec.tf = '{
    opcode: cmdOpcode,
    feature: cmdFeature,
    countCur: cmdCountCur,
    countPrev: cmdCountPrev,
    lbaLowCur: cmdLbaLowCur,
    lbaMidCur: cmdLbaMidCur,
    lbaMidPrev: cmdLbaMidPrev,
    lbaHighCur: cmdLbaHighCur
  };

  sld_tf_match u_match
  (
    .dec(dec)
  );

  // sector count the host asks to move, resized to the counter width
  assign reqCount = CNT_W'(cmdCountCur);
  assign countOver = reqCount > st_ff.needSect;

  // one decision per command; pulses last exactly one cycle
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.accept = 1'b0;
    nxt_st.abort = 1'b0;
    nxt_st.passOn = 1'b0;
    nxt_st.rdGo = 1'b0;
    nxt_st.wrGo = 1'b0;
    nxt_st.statGo = 1'b0;
    if (cmdValid)
    begin
      unique case (dec.kind)
        SLD_NONE:
          nxt_st.passOn = 1'b1;
        SLD_BAD:
          nxt_st.abort = 1'b1;
        SLD_STAT:
        begin
          // nothing here touches bgBusy or power: read-only service
          nxt_st.accept = 1'b1;
          nxt_st.statGo = 1'b1;
        end
        SLD_DATA:
        begin
          if (!st_ff.keyPend)
          begin
            nxt_st.abort = 1'b1;
            nxt_st.lastStat = XS_NO_REQUEST;
          end
          else if (countOver)
          begin
            nxt_st.abort = 1'b1;
            nxt_st.lastStat = XS_COUNT_OVER;
          end
          else
          begin
            // acceptance only; success is left to the status page
            nxt_st.accept = 1'b1;
            nxt_st.rdGo = !dec.isWrite;
            nxt_st.wrGo = dec.isWrite;
            nxt_st.xfer = reqCount;
            nxt_st.needSect = st_ff.needSect - reqCount;
            nxt_st.keyPend = reqCount != st_ff.needSect;
          end
        end
      endcase
    end
    // engine finishing overrides any code set by the same cycle's command
    if (bgDone)
      nxt_st.lastStat = bgStatus;
    // a new key sector wins over a transfer that drained the old one
    if (keyIssued)
    begin
      nxt_st.keyPend = 1'b1;
      nxt_st.needSect = keyNeedSectors;
    end
    // status page word: background marker hides the stored code
    nxt_st.statOut = bgBusy ? XS_BACKGROUND : nxt_st.lastStat;
  end

  // state register
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      st_ff <= '0;
      st_ff.lastStat <= XS_RESET;
      st_ff.statOut <= XS_RESET;
    end
    else
      st_ff <= nxt_st;
  end

  // outputs come straight from the state record
  assign cmdAccept = st_ff.accept;
  assign cmdAbort = st_ff.abort;
  assign cmdPassOn = st_ff.passOn;
  assign dataReadGo = st_ff.rdGo;
  assign dataWriteGo = st_ff.wrGo;
  assign statusReadGo = st_ff.statGo;
  assign xferSectors = st_ff.xfer;
  assign statusCode = st_ff.statOut;
  assign requestPending = st_ff.keyPend;

endmodule
`default_nettype wire

// ===== src/sld_pkg.sv
/*
  constants and types shared by the transport-log command decoder.
  assumes the task-file fields arrive as plain bytes on the system clock.
*/
package sld_pkg;

  // command opcodes and features
  localparam logic [7:0] OP_SMART = 8'hb0;
  localparam logic [7:0] OP_LOG_RD = 8'h2f;
  localparam logic [7:0] OP_LOG_WR = 8'h3f;
  localparam logic [7:0] FEAT_RD = 8'hd5;
  localparam logic [7:0] FEAT_WR = 8'hd6;

  // log pages, key bytes and fixed field values
  localparam logic [7:0] PAGE_STATUS = 8'he0;
  localparam logic [7:0] PAGE_DATA = 8'he1;
  localparam logic [7:0] KEY_LOW = 8'h4f;
  localparam logic [7:0] KEY_HIGH = 8'hc2;
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // extended status codes
  localparam logic [15:0] XS_NO_REQUEST = 16'h000b;
  localparam logic [15:0] XS_COUNT_OVER = 16'h0003;
  localparam logic [15:0] XS_BACKGROUND = 16'hffff;
  localparam logic [15:0] XS_RESET = 16'h0000;

  // task-file snapshot presented with a command
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] feature;
    logic [7:0] countCur;
    logic [7:0] countPrev;
    logic [7:0] lbaLowCur;
    logic [7:0] lbaMidCur;
    logic [7:0] lbaMidPrev;
    logic [7:0] lbaHighCur;
  } sld_tf_t;

  // command classes seen by the decoder
  typedef enum logic [1:0] {
    SLD_NONE,
    SLD_DATA,
    SLD_STAT,
    SLD_BAD
  } sld_kind_t;

endpackage

// ===== src/sld_dec_if.sv
/*
  carrier between the decoder top and its task-file classifier.
  assumes both ends run on one clock; the classifier is combinational.
*/
`timescale 1ns/1ns
`default_nettype none
interface sld_dec_if;
  import sld_pkg::*;

  sld_tf_t tf;
  sld_kind_t kind;
  logic isWrite;

  modport top (output tf, input kind, input isWrite);
  modport match (input tf, output kind, output isWrite);
endinterface
`default_nettype wire

// ===== src/sld_tf_match.sv
/*
  classifies a task-file snapshot as transport data, status, bad or other.
  assumes the snapshot is stable while the top samples the result.
*/
`timescale 1ns/1ns
`default_nettype none
module sld_tf_match
(
  // task file in, class out
  sld_dec_if.match dec
);
  import sld_pkg::*;

  logic smartKeyOk;
  logic extFmtOk;
  logic isPage;

  // key bytes and fixed count fields of each route
  assign smartKeyOk = dec.tf.lbaMidCur == KEY_LOW &&
                      dec.tf.lbaHighCur == KEY_HIGH;
  assign extFmtOk = dec.tf.countCur == CNT_ONE &&
                    dec.tf.countPrev == BYTE_ZERO &&
                    dec.tf.lbaMidCur == BYTE_ZERO &&
                    dec.tf.lbaMidPrev == BYTE_ZERO;
  assign isPage = dec.tf.lbaLowCur == PAGE_DATA ||
                  dec.tf.lbaLowCur == PAGE_STATUS;

  // other pages and opcodes fall through untouched to the rest of the drive
  always_comb
  begin
    dec.kind = SLD_NONE;
    dec.isWrite = 1'b0;
    if (dec.tf.opcode == OP_SMART && isPage)
    begin
      if (dec.tf.lbaLowCur == PAGE_DATA)
      begin
        // zero sectors is rejected as a bad command, not as a count over
        if (smartKeyOk && dec.tf.countCur != BYTE_ZERO &&
            (dec.tf.feature == FEAT_RD || dec.tf.feature == FEAT_WR))
        begin
          dec.kind = SLD_DATA;
          dec.isWrite = dec.tf.feature == FEAT_WR;
        end
        else if (dec.tf.feature == FEAT_RD || dec.tf.feature == FEAT_WR)
          dec.kind = SLD_BAD;
      end
      else if (dec.tf.feature == FEAT_RD)
      begin
        if (smartKeyOk && dec.tf.countCur == CNT_ONE)
          dec.kind = SLD_STAT;
        else
          dec.kind = SLD_BAD;
      end
      else if (dec.tf.feature == FEAT_WR)
        dec.kind = SLD_BAD; // status page cannot be written
    end
    else if ((dec.tf.opcode == OP_LOG_RD || dec.tf.opcode == OP_LOG_WR) &&
             isPage)
    begin
      if (!extFmtOk)
        dec.kind = SLD_BAD;
      else if (dec.tf.lbaLowCur == PAGE_DATA)
      begin
        dec.kind = SLD_DATA;
        dec.isWrite = dec.tf.opcode == OP_LOG_WR;
      end
      else if (dec.tf.opcode == OP_LOG_RD)
        dec.kind = SLD_STAT;
      else
        dec.kind = SLD_BAD;
    end
  end

endmodule
`default_nettype wire

// ===== dv/sld_log_decode_asserts.sv
/*
  concurrent checks on the transport-log decoder top.
  assumes it is bound to sld_log_decode and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none
module sld_log_decode_asserts
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // task file
  input wire logic cmdValid,
  input wire logic [7:0] cmdOpcode,
  input wire logic [7:0] cmdFeature,
  input wire logic [7:0] cmdCountCur,
  input wire logic [7:0] cmdCountPrev,
  input wire logic [7:0] cmdLbaLowCur,
  input wire logic [7:0] cmdLbaMidCur,
  input wire logic [7:0] cmdLbaMidPrev,
  input wire logic [7:0] cmdLbaHighCur,
  // engine events
  input wire logic keyIssued,
  input wire logic bgBusy,
  input wire logic bgDone,
  input wire logic [15:0] bgStatus,
  // answers
  input wire logic cmdAccept,
  input wire logic cmdAbort,
  input wire logic cmdPassOn,
  input wire logic dataReadGo,
  input wire logic dataWriteGo,
  input wire logic statusReadGo,
  input wire logic [15:0] statusCode,
  input wire logic requestPending
);
  import sld_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic logExt;
  logic smartKey;
  // shape of the fixed task-file fields on each route
  assign logExt = cmdCountCur == CNT_ONE && cmdCountPrev == BYTE_ZERO
    && cmdLbaMidCur == BYTE_ZERO && cmdLbaMidPrev == BYTE_ZERO;
  assign smartKey = cmdOpcode == OP_SMART && cmdLbaMidCur == KEY_LOW;
  sequence sStatCmd;
    cmdValid && cmdLbaLowCur == PAGE_STATUS && (logExt && cmdOpcode ==
    OP_LOG_RD || smartKey && cmdLbaHighCur == KEY_HIGH && cmdFeature ==
    FEAT_RD && cmdCountCur == CNT_ONE);
  endsequence
  sequence sNoKeyData;
    cmdValid && logExt && cmdOpcode == OP_LOG_RD && cmdLbaLowCur ==
    PAGE_DATA && !requestPending && !keyIssued && !bgDone;
  endsequence
  // a busy or finishing engine may overwrite the code in that cycle
  sequence sAbortNoted;
    cmdAbort ##1 ($past(bgBusy) || $past(bgDone) ||
    statusCode == XS_NO_REQUEST);
  endsequence
  a_one_answer: assert property (
    cmdValid |=> $onehot({cmdAccept, cmdAbort, cmdPassOn}))
    else $error("not one answer");
  a_no_spont: assert property (
    !cmdValid |=> !(cmdAccept || cmdAbort || cmdPassOn))
    else $error("answer without command");
  a_stat_read: assert property (
    sStatCmd |=> cmdAccept && statusReadGo)
    else $error("status read refused");
  a_nokey_abort: assert property (
    sNoKeyData |=> sAbortNoted)
    else $error("data without key not aborted");
  a_busy_code: assert property (
    bgBusy |=> statusCode == XS_BACKGROUND)
    else $error("busy code wrong");
  a_done_code: assert property (
    bgDone && !bgBusy |=> statusCode == $past(bgStatus))
    else $error("done code wrong");
  a_go_accepted: assert property (
    (dataReadGo || dataWriteGo || statusReadGo) |-> cmdAccept)
    else $error("go without accept");
  a_bad_key: assert property (
    cmdValid && smartKey && cmdLbaLowCur == PAGE_STATUS &&
    cmdFeature == FEAT_RD && cmdLbaHighCur != KEY_HIGH |=> cmdAbort)
    else $error("bad key not aborted");
endmodule
bind sld_log_decode sld_log_decode_asserts i_sld_log_decode_asserts (.*);
`default_nettype wire

// ===== dv/sld_host_model.sv
/*
  host controller model: issues one task-file command per call.
  assumes callers start between clock edges; fields scramble when idle.
*/
`timescale 1ns/1ns
`default_nettype none
module sld_host_model
(
  // clock
  input wire logic sys_clk,
  // task file toward the decoder
  output var logic cmdValid,
  output var sld_pkg::sld_tf_t tf
);
  import sld_pkg::*;
  initial
  begin
    cmdValid = 1'b0;
    tf = '0;
  end
  // fields are inverted once released so stale values never look valid
  task automatic send(input sld_tf_t t);
    @(posedge sys_clk);
    cmdValid <= 1'b1;
    tf <= t;
    @(posedge sys_clk);
    cmdValid <= 1'b0;
    tf <= ~t;
    #1;
  endtask
endmodule
`default_nettype wire

// ===== dv/sct_log_transport_decode_bench.sv
/*
  self-checking bench for the transport-log decoder.
  assumes the host model and bound checker are compiled before it.
*/
`timescale 1ns/1ns
`default_nettype none
module sct_log_transport_decode_bench;
  import sld_pkg::*;
  logic sys_clk, sys_rst, keyIssued, bgBusy, bgDone, cmdValid;
  logic cmdAccept, cmdAbort, cmdPassOn, requestPending;
  logic dataReadGo, dataWriteGo, statusReadGo;
  logic [7:0] keyNeed, xferSectors;
  logic [15:0] bgStatus, statusCode;
  sld_tf_t tf;
  int miscompares = 0;
  int checks = 0;
  sld_host_model i_sld_host_model (.sys_clk(sys_clk),
    .cmdValid(cmdValid), .tf(tf));
  sld_log_decode #(.CNT_W(8)) i_sld_log_decode (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .cmdValid(cmdValid), .cmdOpcode(tf.opcode),
    .cmdFeature(tf.feature), .cmdCountCur(tf.countCur),
    .cmdCountPrev(tf.countPrev), .cmdLbaLowCur(tf.lbaLowCur),
    .cmdLbaMidCur(tf.lbaMidCur), .cmdLbaMidPrev(tf.lbaMidPrev),
    .cmdLbaHighCur(tf.lbaHighCur), .keyIssued(keyIssued),
    .keyNeedSectors(keyNeed), .bgBusy(bgBusy), .bgDone(bgDone),
    .bgStatus(bgStatus), .cmdAccept(cmdAccept), .cmdAbort(cmdAbort),
    .cmdPassOn(cmdPassOn), .dataReadGo(dataReadGo),
    .dataWriteGo(dataWriteGo), .statusReadGo(statusReadGo),
    .xferSectors(xferSectors), .statusCode(statusCode),
    .requestPending(requestPending));
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic print_verdict;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen,
    input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // flags as accept, abort, passOn, readGo, writeGo, statusGo
  task automatic ans(input logic [5:0] exp);
    chk("answer", {10'h000, cmdAccept, cmdAbort, cmdPassOn, dataReadGo,
      dataWriteGo, statusReadGo}, {10'h000, exp});
  endtask
  // engine events are one-cycle pulses with their data
  task automatic ev(input logic k, input logic d, input logic [7:0] n,
    input logic [15:0] s);
    @(posedge sys_clk);
    keyIssued <= k;
    bgDone <= d;
    keyNeed <= n;
    bgStatus <= s;
    @(posedge sys_clk);
    keyIssued <= 1'b0;
    bgDone <= 1'b0;
    #1;
  endtask
  function automatic sld_tf_t smart(input logic [7:0] f, c, pg, hi);
    return '{OP_SMART, f, c, BYTE_ZERO, pg, KEY_LOW, BYTE_ZERO, hi};
  endfunction
  function automatic sld_tf_t logx(input logic [7:0] op, pg, cp);
    return '{op, BYTE_ZERO, CNT_ONE, cp, pg, BYTE_ZERO, BYTE_ZERO,
      BYTE_ZERO};
  endfunction
  initial
  begin
    sys_rst = 1'b1;
    {keyIssued, bgBusy, bgDone, keyNeed, bgStatus} = '0;
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    #1 chk("status", statusCode, XS_RESET);
    i_sld_host_model.send(logx(OP_LOG_RD, PAGE_DATA, BYTE_ZERO));
    ans(6'b010000);
    @(posedge sys_clk);
    #1 chk("xstatus", statusCode, XS_NO_REQUEST);
    ev(1'b1, 1'b0, 8'h03, 16'h0000);
    chk("pending", {15'h0000, requestPending}, 16'h0001);
    i_sld_host_model.send(smart(FEAT_WR, 8'h02, PAGE_DATA, KEY_HIGH));
    ans(6'b100010);
    chk("sectors", {8'h00, xferSectors}, 16'h0002);
    i_sld_host_model.send(logx(OP_LOG_RD, PAGE_DATA, BYTE_ZERO));
    ans(6'b100100);
    chk("pending", {15'h0000, requestPending}, 16'h0000);
    ev(1'b1, 1'b0, 8'h01, 16'h0000);
    i_sld_host_model.send(smart(FEAT_RD, 8'h02, PAGE_DATA, KEY_HIGH));
    ans(6'b010000);
    @(posedge sys_clk);
    #1 chk("xstatus", statusCode, XS_COUNT_OVER);
    i_sld_host_model.send(logx(OP_LOG_WR, PAGE_DATA, BYTE_ZERO));
    ans(6'b100010);
    i_sld_host_model.send(smart(FEAT_RD, CNT_ONE, PAGE_STATUS, 8'h00));
    ans(6'b010000);
    i_sld_host_model.send(logx(OP_LOG_RD, PAGE_STATUS, 8'h01));
    ans(6'b010000);
    @(posedge sys_clk);
    bgBusy <= 1'b1;
    i_sld_host_model.send(smart(FEAT_RD, CNT_ONE, PAGE_STATUS, KEY_HIGH));
    ans(6'b100001);
    chk("xstatus", statusCode, XS_BACKGROUND);
    i_sld_host_model.send(logx(OP_LOG_RD, PAGE_STATUS, BYTE_ZERO));
    ans(6'b100001);
    chk("xstatus", statusCode, XS_BACKGROUND);
    @(posedge sys_clk);
    bgBusy <= 1'b0;
    ev(1'b0, 1'b1, 8'h00, 16'h0011);
    chk("xstatus", statusCode, 16'h0011);
    i_sld_host_model.send('{8'hc8, FEAT_RD, CNT_ONE, BYTE_ZERO,
      PAGE_DATA, KEY_LOW, BYTE_ZERO, KEY_HIGH});
    ans(6'b001000);
    print_verdict();
  end
  // the sequence needs well under a hundred cycles
  initial
  begin
    repeat (2000) @(posedge sys_clk);
    miscompares++;
    print_verdict();
  end
endmodule
`default_nettype wire
